// *** core/ncp_nco_tuning_phase_regs.sv ***
`timescale 1ns/10ps
// Functional notes
// - oscillator frequency equals tuning word over two to the 32 times sample rate.
// - tuning word acts only while the down-converter enable bit at 0x80 is one.
// - tuning word bytes 15:8, 23:16, 31:24 live at 0x83, 0x84, 0x85.
// - tuning word byte 7:0 lives at 0x82; zero word gives a DC oscillator.
// - phase offset code is two to the 16 times degrees over 360.
// - first channel offset low at 0x86, high at 0x87; second channel low at 0x88.
// - second channel phase offset high byte lives at 0x89.
// - offsets apply only in octal CW or single/dual modes with down-conversion.
// - offset slot 0 serves first listed channel, slot 1 the second.
module ncp_nco_tuning_phase_regs
  import ncp_pkg::*;
#(
  parameter bit HAS_DOWNCONV = 1'b1
) (
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [ncp_pkg::ADDR_W-1:0] paddr,
  input  wire logic [ncp_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]               pstrb,
  output logic                          pready,
  output logic                          pslverr,
  output logic [ncp_pkg::DATA_W-1:0]    prdata,
  // channel sequence position of the current sample
  input  wire logic                     chan_slot_sel,
  // oscillator outputs
  output logic [ncp_pkg::PHASE_W-1:0]   nco_phase,
  output logic                          nco_active
);
  import ncp_pkg::*;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic [7:0]         freq_b0_reg, freq_b1_reg, freq_b2_reg, freq_b3_reg;
  logic [7:0]         ph0_lo_reg, ph0_hi_reg, ph1_lo_reg, ph1_hi_reg;
  logic               dc_enable_reg;
  logic [MODE_W-1:0]  mode_reg;
  logic [ACC_W-1:0]   acc_reg;
  logic [ACC_W-1:0]   acc_next;
  logic [PHASE_W-1:0] phase_next;
  logic               pready_reg, pslverr_reg;
  logic [DATA_W-1:0]  prdata_reg;
  logic [PHASE_W-1:0] nco_phase_reg;
  logic               nco_active_reg;

  wire [IDX_W-1:0] idx      = paddr[ADDR_W-1:2];
  wire             aligned  = (paddr[1:0] == 2'b00);
  wire             setup    = psel & ~penable;
  wire             wr_phase = psel & penable & pwrite & aligned & pstrb[0];
  wire [7:0]       wbyte    = pwdata[7:0];

  // one write strobe per index; low lane carries every register
  function automatic logic wr_hit(input logic [IDX_W-1:0] at_idx, input logic strobe,
                                  input logic [IDX_W-1:0] target);
    wr_hit = strobe & (at_idx == target);
  endfunction

  wire [ACC_W-1:0]   freq_word = {freq_b3_reg, freq_b2_reg, freq_b1_reg, freq_b0_reg};
  wire [PHASE_W-1:0] ph0       = {ph0_hi_reg, ph0_lo_reg};
  wire [PHASE_W-1:0] ph1       = {ph1_hi_reg, ph1_lo_reg};

  // offsets are meaningless without a down-converter in the part
  wire mode_uses_phase = (mode_reg == MODE_SINGLE) | (mode_reg == MODE_DUAL) |
                         (mode_reg == MODE_OCTAL_CW);
  wire phase_on  = HAS_DOWNCONV & dc_enable_reg & mode_uses_phase;
  wire word_on   = HAS_DOWNCONV & dc_enable_reg;
  wire [PHASE_W-1:0] slot_ofs = chan_slot_sel ? ph1 : ph0;

  // ----------------------------------------
  // read mux; a word's spare upper bits read as zero
  // ----------------------------------------
  logic [DATA_W-1:0] rd_data;
  logic              rd_hit;
  always_comb begin
    rd_data = DATA_ZERO;
    rd_hit  = 1'b1;
    case (idx)
      IDX_DC_CTRL:    rd_data[DC_ENABLE_BIT] = dc_enable_reg;
      IDX_FREQ_BYTE0: rd_data[7:0] = freq_b0_reg;
      IDX_FREQ_BYTE1: rd_data[7:0] = freq_b1_reg;
      IDX_FREQ_BYTE2: rd_data[7:0] = freq_b2_reg;
      IDX_FREQ_BYTE3: rd_data[7:0] = freq_b3_reg;
      IDX_PH0_LOW:    rd_data[7:0] = ph0_lo_reg;
      IDX_PH0_HIGH:   rd_data[7:0] = ph0_hi_reg;
      IDX_PH1_LOW:    rd_data[7:0] = ph1_lo_reg;
      IDX_PH1_HIGH:   rd_data[7:0] = ph1_hi_reg;
      IDX_MODE:       rd_data[MODE_W-1:0] = mode_reg;
      IDX_STATUS:     rd_data[PHASE_W-1:0] = nco_phase_reg;
      default:        rd_hit = 1'b0;
    endcase
    if (!aligned) begin
      rd_hit = 1'b0;
    end
  end

  // ----------------------------------------
  // apb answer: prepared in setup so access completes with no wait
  // ----------------------------------------
  // a write or a refused access returns zero so stale data never leaks out
  wire [DATA_W-1:0] rd_sel = (pwrite || !rd_hit) ? DATA_ZERO : rd_data;

  // the slave never stretches a transfer, so ready stands high after reset;
  // a constant ready still sits in a flop so the pin has no logic before it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b1;
    end else if (setup) begin
      pready_reg <= 1'b1;
    end
  end

  // error is decided at setup and stands until the next setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      pslverr_reg <= ~rd_hit;
    end
  end

  // read data is latched at setup and stands through the access phase;
  // the status word is therefore a snapshot taken at the setup edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= DATA_ZERO;
    end else if (setup) begin
      prdata_reg <= rd_sel;
    end
  end

  // ----------------------------------------
  // register write strobes; status is read-only and ignores writes
  // ----------------------------------------
  // only the low byte lane carries data; a clear pstrb[0] drops the write quietly
  // writes to the status index find no strobe here and vanish
  wire wr_ctl   = wr_hit(idx, wr_phase, IDX_DC_CTRL);
  wire wr_mode  = wr_hit(idx, wr_phase, IDX_MODE);
  wire wr_f0    = wr_hit(idx, wr_phase, IDX_FREQ_BYTE0);
  wire wr_f1    = wr_hit(idx, wr_phase, IDX_FREQ_BYTE1);
  wire wr_f2    = wr_hit(idx, wr_phase, IDX_FREQ_BYTE2);
  wire wr_f3    = wr_hit(idx, wr_phase, IDX_FREQ_BYTE3);
  wire wr_p0_lo = wr_hit(idx, wr_phase, IDX_PH0_LOW);
  wire wr_p0_hi = wr_hit(idx, wr_phase, IDX_PH0_HIGH);
  wire wr_p1_lo = wr_hit(idx, wr_phase, IDX_PH1_LOW);
  wire wr_p1_hi = wr_hit(idx, wr_phase, IDX_PH1_HIGH);

  // ----------------------------------------
  // control and mode
  // ----------------------------------------
  // one enable gates both the tuning word and the offsets;
  // clearing it parks the accumulator so the next start begins at phase zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dc_enable_reg <= 1'b0;
    end else if (wr_ctl) begin
      dc_enable_reg <= wbyte[DC_ENABLE_BIT];
    end
  end

  // channel mode decides whether the offsets take part;
  // octal mode without continuous wave takes none
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= MODE_SINGLE;
    end else if (wr_mode) begin
      mode_reg <= wbyte[MODE_W-1:0];
    end
  end

  // ----------------------------------------
  // tuning word bytes
  // ----------------------------------------
  // bytes take effect one at a time with no shadow copy: a running word
  // passes through mixed values while it is rewritten, so clear the enable
  // before changing more than one byte
  // bits 7:0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_b0_reg <= BYTE_RST;
    end else if (wr_f0) begin
      freq_b0_reg <= wbyte;
    end
  end

  // bits 15:8
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_b1_reg <= BYTE_RST;
    end else if (wr_f1) begin
      freq_b1_reg <= wbyte;
    end
  end

  // bits 23:16
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_b2_reg <= BYTE_RST;
    end else if (wr_f2) begin
      freq_b2_reg <= wbyte;
    end
  end

  // bits 31:24
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_b3_reg <= BYTE_RST;
    end else if (wr_f3) begin
      freq_b3_reg <= wbyte;
    end
  end

  // ----------------------------------------
  // phase offset bytes
  // ----------------------------------------
  // plain storage here; the enable and the mode decide whether they are used,
  // slot 0 feeding the first listed channel and slot 1 the second
  // first channel, low byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph0_lo_reg <= BYTE_RST;
    end else if (wr_p0_lo) begin
      ph0_lo_reg <= wbyte;
    end
  end

  // first channel, high byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph0_hi_reg <= BYTE_RST;
    end else if (wr_p0_hi) begin
      ph0_hi_reg <= wbyte;
    end
  end

  // second channel, low byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph1_lo_reg <= BYTE_RST;
    end else if (wr_p1_lo) begin
      ph1_lo_reg <= wbyte;
    end
  end

  // second channel, high byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph1_hi_reg <= BYTE_RST;
    end else if (wr_p1_hi) begin
      ph1_hi_reg <= wbyte;
    end
  end

  // ----------------------------------------
  // oscillator: modulo 2^32 wrap gives f = word / 2^32 * fs
  // ----------------------------------------
  // the sum drops its carry on purpose: that carry is the wrap itself
  assign acc_next   = word_on ? acc_reg + freq_word : FREQ_RST;
  // the full 16-bit offset spans one turn: code = 2^16 * deg / 360
  // offsets wrap the same way, so 16'hFFFF sits just short of a full turn
  assign phase_next = acc_reg[ACC_W-1 -: PHASE_W] + (phase_on ? slot_ofs : PHASE_RST);

  // accumulator parks at zero while disabled so restarts are repeatable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= FREQ_RST;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // phase is built from the accumulator before this edge: one sample of lag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nco_phase_reg <= PHASE_RST;
    end else begin
      nco_phase_reg <= phase_next;
    end
  end

  // active follows the enable by one edge, one edge ahead of the first moving phase;
  // it is the only sign outside the block that the word is in use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nco_active_reg <= 1'b0;
    end else begin
      nco_active_reg <= word_on;
    end
  end

  // ----------------------------------------
  // outputs: every one comes straight from a flip-flop
  // ----------------------------------------
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign prdata     = prdata_reg;
  assign nco_phase  = nco_phase_reg;
  assign nco_active = nco_active_reg;
endmodule

// *** core/ncp_pkg.sv ***
package ncp_pkg;
  // ----------------------------------------
  // bus geometry
  // ----------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W  = 10;

  // ----------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------
  localparam logic [IDX_W-1:0] IDX_DC_CTRL    = 10'h080;
  localparam logic [IDX_W-1:0] IDX_FREQ_BYTE0 = 10'h082;
  localparam logic [IDX_W-1:0] IDX_FREQ_BYTE1 = 10'h083;
  localparam logic [IDX_W-1:0] IDX_FREQ_BYTE2 = 10'h084;
  localparam logic [IDX_W-1:0] IDX_FREQ_BYTE3 = 10'h085;
  localparam logic [IDX_W-1:0] IDX_PH0_LOW    = 10'h086;
  localparam logic [IDX_W-1:0] IDX_PH0_HIGH   = 10'h087;
  localparam logic [IDX_W-1:0] IDX_PH1_LOW    = 10'h088;
  localparam logic [IDX_W-1:0] IDX_PH1_HIGH   = 10'h089;
  localparam logic [IDX_W-1:0] IDX_MODE       = 10'h0C0;
  localparam logic [IDX_W-1:0] IDX_STATUS     = 10'h0C1;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int unsigned DC_ENABLE_BIT = 0;
  localparam int unsigned MODE_W        = 2;
  localparam int unsigned ACC_W         = 32;
  localparam int unsigned PHASE_W       = 16;
  localparam logic [7:0]         BYTE_RST  = 8'h00;
  localparam logic [ACC_W-1:0]   FREQ_RST  = 32'h0000_0000;
  localparam logic [PHASE_W-1:0] PHASE_RST = 16'h0000;
  localparam logic [DATA_W-1:0]  DATA_ZERO = 32'h0000_0000;

  // ----------------------------------------
  // channel mode codes held in the mode register
  // ----------------------------------------
  localparam logic [MODE_W-1:0] MODE_SINGLE   = 2'h0;
  localparam logic [MODE_W-1:0] MODE_DUAL     = 2'h1;
  localparam logic [MODE_W-1:0] MODE_OCTAL    = 2'h2;
  localparam logic [MODE_W-1:0] MODE_OCTAL_CW = 2'h3;
endpackage

// *** sim/ncp_properties.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// port checks for the register slice
// ----------------------------------------
module ncp_properties
  import ncp_pkg::*;
(
  // clock, reset and bus
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [ncp_pkg::ADDR_W-1:0]  paddr,
  input wire logic [ncp_pkg::DATA_W-1:0]  pwdata,
  input wire logic [3:0]                  pstrb,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic [ncp_pkg::DATA_W-1:0]  prdata,
  // oscillator side
  input wire logic                        chan_slot_sel,
  input wire logic [ncp_pkg::PHASE_W-1:0] nco_phase,
  input wire logic                        nco_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // decodes; byte reads span tuning word and both offsets
  wire setup   = psel && !penable;
  wire wr_ctl  = psel && penable && pwrite && pstrb[0] && paddr == {IDX_DC_CTRL, 2'b00};
  wire byte_rd = setup && !pwrite && paddr >= {IDX_FREQ_BYTE0, 2'b00} && paddr <= {IDX_PH1_HIGH, 2'b00};
  sequence s_ctl_wr(b);
    wr_ctl && pwdata[0] == b;
  endsequence
  property p_rdy; setup |=> pready; endproperty
  property p_err; setup && paddr[1:0] != 2'b00 |=> pslverr; endproperty
  property p_wzero; setup && pwrite |=> prdata == DATA_ZERO; endproperty
  property p_hi; byte_rd && paddr[1:0] == 2'b00 |=> !pslverr && prdata[31:8] == 24'h00_0000; endproperty
  property p_on; s_ctl_wr(1'b1) |-> ##[1:2] nco_active; endproperty
  property p_off; s_ctl_wr(1'b0) |-> ##[1:2] !nco_active; endproperty
  property p_dis; !nco_active [*3] |-> nco_phase == PHASE_RST; endproperty
  property p_rd_hold; setup ##1 psel && penable |=> $stable(prdata) && $stable(pslverr); endproperty
  a_rdy: assert property (p_rdy) else $error("pready low in access");
  a_err: assert property (p_err) else $error("misaligned access not refused");
  a_wzero: assert property (p_wzero) else $error("write returned data");
  a_hi: assert property (p_hi) else $error("byte register read wrong");
  a_on: assert property (p_on) else $error("oscillator not enabled");
  a_off: assert property (p_off) else $error("oscillator not disabled");
  a_dis: assert property (p_dis) else $error("phase moves while disabled");
  a_rd_hold: assert property (p_rd_hold) else $error("read data changed");
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  import ncp_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sel = 0, err;
  logic [ADDR_W-1:0]  paddr = '0;
  logic [DATA_W-1:0]  pwdata = '0, prdata, rd;
  logic [3:0]         pstrb = 4'h1;
  logic               pready, pslverr, nco_active;
  logic [PHASE_W-1:0] nco_phase, ph;
  int error_cnt = 0, n_checks = 0, cyc = 0;
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
  ncp_nco_tuning_phase_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .chan_slot_sel(sel), .nco_phase(nco_phase), .nco_active(nco_active));
  always #2 pclk = ~pclk;
  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 5000) begin
      error_cnt++;
      end_sim();
    end
  end
  function automatic logic [11:0] ba(logic [9:0] i);
    return {i, 2'b00};
  endfunction
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    // let an edge pass so back-to-back calls never drive psel twice at once
    @(posedge pclk);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // reset values, then write all bytes before reading any back
  task automatic t_regs;
    for (int i = 0; i < 8; i++) begin
      apb(0, ba(IDX_FREQ_BYTE0 + 10'(i)), DATA_ZERO);
      `CHK(rd, DATA_ZERO)
      apb(1, ba(IDX_FREQ_BYTE0 + 10'(i)), 32'hABCD_EF10 + i);
    end
    for (int i = 0; i < 8; i++) begin
      apb(0, ba(IDX_FREQ_BYTE0 + 10'(i)), DATA_ZERO);
      `CHK(rd, 32'h0000_0010 + i)
      `CHK(err, 1'b0)
    end
    apb(0, 12'h201, DATA_ZERO);
    `CHK(err, 1'b1)
    apb(1, 12'h400, 32'h1);
    `CHK(err, 1'b1)
    pstrb <= 4'h0;
    apb(1, ba(IDX_FREQ_BYTE0), 32'h55);
    pstrb <= 4'h1;
    apb(0, ba(IDX_FREQ_BYTE0), DATA_ZERO);
    `CHK(rd, 32'h0000_0010)
    $display("test regs done");
  endtask
  // word zero leaves only the offsets; then a running accumulator
  task automatic t_nco;
    for (int i = 0; i < 8; i++) apb(1, ba(IDX_FREQ_BYTE0 + 10'(i)), (i == 5) ? 32'h40 : (i == 7) ? 32'h80 : 0);
    apb(1, ba(IDX_MODE), 32'(MODE_SINGLE));
    apb(1, ba(IDX_DC_CTRL), 32'h1);
    repeat (3) @(posedge pclk);
    `CHK(nco_phase, 16'(65536 * 90 / 360))
    `CHK(nco_active, 1'b1)
    apb(0, ba(IDX_STATUS), DATA_ZERO);
    `CHK(rd, 32'(65536 * 90 / 360))
    sel <= 1;
    repeat (3) @(posedge pclk);
    `CHK(nco_phase, 16'(65536 * 180 / 360))
    apb(1, ba(IDX_MODE), 32'(MODE_DUAL));
    repeat (3) @(posedge pclk);
    `CHK(nco_phase, 16'(65536 * 180 / 360))
    apb(1, ba(IDX_MODE), 32'(MODE_OCTAL));
    repeat (3) @(posedge pclk);
    `CHK(nco_phase, PHASE_RST)
    apb(1, ba(IDX_MODE), 32'(MODE_OCTAL_CW));
    apb(1, ba(IDX_FREQ_BYTE3), 32'h1);
    repeat (3) @(posedge pclk);
    ph = nco_phase;
    @(posedge pclk);
    `CHK(16'(nco_phase - ph), 16'h0100)
    apb(1, ba(IDX_DC_CTRL), DATA_ZERO);
    repeat (4) @(posedge pclk);
    `CHK(nco_phase, PHASE_RST)
    `CHK(nco_active, 1'b0)
    $display("test nco done");
  endtask
  // reset in mid-run, with the oscillator running, clears bytes and outputs
  task automatic t_rst;
    apb(1, ba(IDX_DC_CTRL), 32'h1);
    repeat (2) @(posedge pclk);
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    `CHK(nco_active, 1'b0)
    `CHK(nco_phase, PHASE_RST)
    apb(0, ba(IDX_PH1_HIGH), DATA_ZERO);
    `CHK(rd, DATA_ZERO)
    $display("test reset done");
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_regs();
    t_nco();
    t_rst();
    end_sim();
  end
endmodule
bind ncp_nco_tuning_phase_regs ncp_properties i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .chan_slot_sel(chan_slot_sel), .nco_phase(nco_phase),
  .nco_active(nco_active));
